// [ctic_config.sv]
// Command type selection, I/O function defaults and menu
// access control. Assumes a plain register port driven by
// a panel or host, synchronous to clk_sys_in.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ctic_consts.svh"
module ctic_config #(
  parameter int unsigned IDLE_CYCLES = `CTIC_IDLE_CYC
) (
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 reset_in,
  // Register port
  input  wire ctic_pkg::ctic_req_t  req_in,
  output logic [15:0]               rdata_out,
  output logic                      rdata_hex_out,
  // Motor events
  input  wire logic                 motor_mismatch_in,
  input  wire logic                 motor_ext_change_in,
  // Configuration results
  output var ctic_pkg::ctic_io_map_t io_map_out,
  output logic signed [7:0]         op_mode_out,
  output logic [15:0]               gear_num_out,
  output logic [15:0]               gear_den_out,
  output logic                      gear_active_out,
  output logic [15:0]               speed_factor_out,
  output logic                      speed_active_out,
  output logic [3:0]                analog_src_out,
  output logic                      limits_off_out,
  output logic                      alarm_open_out,
  // Loop setup and persistence
  output logic [3:0]                loop_load_out,
  output logic [3:0]                loop_app_out,
  output logic                      save_pulse_out,
  output logic                      unsaved_out,
  output logic                      menu_locked_out,
  output logic                      menu_open_out
);
  import ctic_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Decimal digit n (0 = rightmost) of a value
  function automatic logic [3:0] dig(
    input logic [15:0] v,
    input int          n
  );
    logic [15:0] q;
    q = v;
    for (int i = 0; i < 3; i++) begin
      if (i < n) begin
        q = q / 16'd10;
      end
    end
    dig = 4'((q % 16'd10));
  endfunction

  // Pulse train command types
  function automatic logic is_pulse(input logic [3:0] c);
    is_pulse = (c <= 4'h2);
  endfunction

  // Analog velocity command types
  function automatic logic is_analog(input logic [3:0] c);
    is_analog = (c == 4'h6) || (c == 4'h7);
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [3:0]  cmd_ff;
  logic [15:0] gnum_ff;
  logic [15:0] gden_ff;
  logic [15:0] speed_ff;
  logic [15:0] cfg_ff;
  logic [15:0] motor_ff;
  logic [15:0] tune_ff;
  ctic_menu_t  menu_ff;
  ctic_menu_t  nxt_menu;
  logic [31:0] idle_cnt_ff;
  logic        locked;
  logic        wr_ok;
  logic        confirm;
  logic        wr_save;
  logic [15:0] rd_val;
  logic [15:0] speed_wr;

  assign locked  = (menu_ff == CTIC_M_LOCKED);
  assign confirm = req_in.wr &&
                   (req_in.addr == `CTIC_OFS_MOTOR);
  assign wr_save = req_in.wr &&
                   (req_in.addr == `CTIC_OFS_SAVE);
  // Locked menus accept nothing but the three safe entries
  assign wr_ok   = req_in.wr && !locked;

  // Standard motors cap the factor; larger writes saturate
  assign speed_wr = (req_in.wdata > `CTIC_MAX_SPEED) ?
                    `CTIC_MAX_SPEED : req_in.wdata;

  // Parameter registers; confirm reloads every default
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || confirm) begin
      cmd_ff   <= `CTIC_RST_CMD;
      gnum_ff  <= `CTIC_RST_GEAR;
      gden_ff  <= `CTIC_RST_GEAR;
      speed_ff <= `CTIC_RST_SPEED;
      cfg_ff   <= `CTIC_RST_CFG;
    end else if (wr_ok) begin
      case (req_in.addr)
        `CTIC_OFS_CMD: begin
          cmd_ff <= req_in.wdata[3:0];
        end
        `CTIC_OFS_GNUM: begin
          gnum_ff <= req_in.wdata;
        end
        `CTIC_OFS_GDEN: begin
          gden_ff <= req_in.wdata;
        end
        `CTIC_OFS_SPEED: begin
          speed_ff <= speed_wr;
        end
        `CTIC_OFS_CFG: begin
          cfg_ff <= req_in.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Motor type and tuning entry stay writable when locked
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      motor_ff <= 16'h0000;
      tune_ff  <= 16'h0000;
    end else if (req_in.wr) begin
      if (req_in.addr == `CTIC_OFS_MOTOR) begin
        motor_ff <= req_in.wdata;
      end
      if (req_in.addr == `CTIC_OFS_TUNE) begin
        tune_ff <= req_in.wdata;
      end
    end
  end

  // ----------------------------------------
  // Menu access state
  // ----------------------------------------

  // Lock on init, mismatch or foreign motor change
  always_comb begin
    nxt_menu = menu_ff;
    case (menu_ff)
      CTIC_M_LOCKED: begin
        if (confirm) begin
          nxt_menu = CTIC_M_OPEN;
        end
      end
      CTIC_M_OPEN: begin
        if (idle_cnt_ff >= IDLE_CYCLES - 1) begin
          nxt_menu = CTIC_M_IDLE;
        end
      end
      CTIC_M_IDLE: begin
        if (req_in.wr || req_in.rd) begin
          nxt_menu = CTIC_M_OPEN;
        end
      end
      default: begin
        nxt_menu = CTIC_M_LOCKED;
      end
    endcase
    // A lock event wins over any access in the same cycle
    if (motor_mismatch_in || motor_ext_change_in) begin
      nxt_menu = CTIC_M_LOCKED;
    end
  end

  // Menu state register; reset counts as initialisation
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      menu_ff <= CTIC_M_LOCKED;
    end else begin
      menu_ff <= nxt_menu;
    end
  end

  // Idle timer restarts on every access
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || req_in.wr || req_in.rd ||
        menu_ff != CTIC_M_OPEN) begin
      idle_cnt_ff <= 32'h0000_0000;
    end else begin
      idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------

  // Hidden entries read zero while locked
  always_comb begin
    rd_val = 16'h0000;
    case (req_in.addr)
      `CTIC_OFS_MOTOR: begin
        rd_val = motor_ff;
      end
      `CTIC_OFS_TUNE: begin
        rd_val = tune_ff;
      end
      `CTIC_OFS_CMD: begin
        rd_val = locked ? 16'h0000 : {12'h000, cmd_ff};
      end
      `CTIC_OFS_GNUM: begin
        rd_val = locked ? 16'h0000 : gnum_ff;
      end
      `CTIC_OFS_GDEN: begin
        rd_val = locked ? 16'h0000 : gden_ff;
      end
      `CTIC_OFS_SPEED: begin
        rd_val = locked ? 16'h0000 : speed_ff;
      end
      `CTIC_OFS_CFG: begin
        rd_val = locked ? 16'h0000 : cfg_ff;
      end
      `CTIC_OFS_STATUS: begin
        rd_val = {13'h0000, unsaved_out,
                  menu_ff == CTIC_M_OPEN, locked};
      end
      default: begin
        rd_val = 16'h0000;
      end
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !req_in.rd) begin
      rdata_out     <= 16'h0000;
      rdata_hex_out <= 1'b0;
    end else begin
      rdata_out     <= rd_val;
      rdata_hex_out <= (rd_val > `CTIC_HEX_LIMIT);
    end
  end

  // ----------------------------------------
  // Command type decode
  // ----------------------------------------

  // Initial operation mode per command type
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      op_mode_out <= -8'sd4;
    end else begin
      case (cmd_ff)
        4'h0, 4'h1, 4'h2: begin
          op_mode_out <= -8'sd4;
        end
        4'h6, 4'h7: begin
          op_mode_out <= -8'sd3;
        end
        4'h9: begin
          op_mode_out <= 8'sd1;
        end
        default: begin
          op_mode_out <= 8'sd0;
        end
      endcase
    end
  end

  // Analog source: 1 or 2, 0 when not analog
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      analog_src_out <= 4'h0;
    end else begin
      analog_src_out <= (cmd_ff == 4'h6) ? 4'h1 :
                        (cmd_ff == 4'h7) ? 4'h2 :
                        4'h0;
    end
  end

  // Gear and speed factors pass only in matching modes
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      gear_active_out  <= 1'b1;
      gear_num_out     <= `CTIC_RST_GEAR;
      gear_den_out     <= `CTIC_RST_GEAR;
      speed_active_out <= 1'b0;
      speed_factor_out <= 16'h0000;
    end else begin
      gear_active_out  <= is_pulse(cmd_ff);
      gear_num_out     <= is_pulse(cmd_ff) ? gnum_ff : 16'h0000;
      gear_den_out     <= is_pulse(cmd_ff) ? gden_ff : 16'h0000;
      speed_active_out <= is_analog(cmd_ff);
      speed_factor_out <= is_analog(cmd_ff) ? speed_ff : 16'h0000;
    end
  end

  // Digit 3 and 4 take effect immediately
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      limits_off_out <= 1'b0;
      alarm_open_out <= 1'b1;
    end else begin
      limits_off_out <= (dig(cfg_ff, 2) == 4'h1);
      alarm_open_out <= (dig(cfg_ff, 3) == 4'h1);
    end
  end

  // ----------------------------------------
  // I/O function defaults
  // ----------------------------------------

  // Whole map rebuilt at once from the current command type and config,
  // so no mix of old and new assignments is ever visible
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      io_map_out <= '0;
    end else begin
      io_map_out <= '0;
      if (cmd_ff != 4'h8) begin
        io_map_out.din[1] <= CTIC_DI_ENABLE;
        io_map_out.din[2] <= CTIC_DI_ERRRST;
        io_map_out.din[3] <= CTIC_DI_HOMEGO;
      end
      io_map_out.din[7] <= CTIC_DI_HOME;
      if (cmd_ff == 4'h9) begin
        io_map_out.din[4]  <= CTIC_DI_IDX0;
        io_map_out.din[5]  <= CTIC_DI_IDX1;
        io_map_out.din[6]  <= CTIC_DI_TBLGO;
        io_map_out.dout[4] <= CTIC_DO_TBLACT;
      end else begin
        // Limit inputs dropped when the config removes them
        if (dig(cfg_ff, 2) != 4'h1) begin
          io_map_out.din[4] <= CTIC_DI_LIMP;
          io_map_out.din[5] <= CTIC_DI_LIMN;
        end
        io_map_out.dout[4] <= CTIC_DO_ZERO;
      end
      io_map_out.dout[1] <= CTIC_DO_READY;
      io_map_out.dout[2] <= CTIC_DO_BRAKE;
      io_map_out.dout[3] <= is_analog(cmd_ff) ?
                            CTIC_DO_VELOK : CTIC_DO_POSOK;
      io_map_out.dout[5] <= CTIC_DO_ERROR;
    end
  end

  // ----------------------------------------
  // Save and loop setup
  // ----------------------------------------

  // Loop setup follows the digits only when saved
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      loop_load_out  <= 4'h1;
      loop_app_out   <= 4'h0;
      save_pulse_out <= 1'b0;
    end else begin
      save_pulse_out <= wr_save;
      if (wr_save) begin
        loop_load_out <= dig(cfg_ff, 0);
        loop_app_out  <= dig(cfg_ff, 1);
      end
    end
  end

  // Edits stay volatile until a save; the operator must
  // save and reboot after a motor change
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      unsaved_out <= 1'b0;
    end else if (wr_ok && !wr_save) begin
      unsaved_out <= 1'b1;
    end else if (wr_save) begin
      unsaved_out <= 1'b0;
    end
  end

  // Menu state shown on pins
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      menu_locked_out <= 1'b1;
      menu_open_out   <= 1'b0;
    end else begin
      menu_locked_out <= (nxt_menu == CTIC_M_LOCKED);
      menu_open_out   <= (nxt_menu == CTIC_M_OPEN);
    end
  end

endmodule
`default_nettype wire

// [ctic_consts.svh]
// Constants of the command-type and I/O configuration block.
// Assumes inclusion by bare name from the package and the block.
`ifndef CTIC_CONSTS_SVH
`define CTIC_CONSTS_SVH
// Register offsets
`define CTIC_OFS_SAVE    4'h0
`define CTIC_OFS_MOTOR   4'h1
`define CTIC_OFS_CMD     4'h2
`define CTIC_OFS_GNUM    4'h3
`define CTIC_OFS_GDEN    4'h4
`define CTIC_OFS_SPEED   4'h5
`define CTIC_OFS_CFG     4'h6
`define CTIC_OFS_TUNE    4'h7
`define CTIC_OFS_STATUS  4'h8
// Reset values and limits
`define CTIC_RST_CMD     4'h1
`define CTIC_RST_GEAR    16'h03e8
`define CTIC_RST_SPEED   16'h012c
`define CTIC_MAX_SPEED   16'h0176
`define CTIC_RST_CFG     16'h03e9
`define CTIC_HEX_LIMIT   16'h270f
// Timing
`define CTIC_CLK_HZ      10000000
`define CTIC_IDLE_S      30
`define CTIC_IDLE_CYC    (`CTIC_IDLE_S * `CTIC_CLK_HZ)
`endif

// [ctic_pkg.sv]
// Types of the command-type and I/O configuration block.
// Assumes the constants header is on the include path.
`include "ctic_consts.svh"
package ctic_pkg;
  // Input function codes
  typedef enum logic [3:0] {
    CTIC_DI_NONE   = 4'h0,
    CTIC_DI_ENABLE = 4'h1,
    CTIC_DI_ERRRST = 4'h2,
    CTIC_DI_HOMEGO = 4'h3,
    CTIC_DI_LIMP   = 4'h4,
    CTIC_DI_LIMN   = 4'h5,
    CTIC_DI_IDX0   = 4'h6,
    CTIC_DI_IDX1   = 4'h7,
    CTIC_DI_TBLGO  = 4'h8,
    CTIC_DI_HOME   = 4'h9
  } ctic_di_fn_t;
  // Output function codes
  typedef enum logic [3:0] {
    CTIC_DO_READY  = 4'h1,
    CTIC_DO_BRAKE  = 4'h2,
    CTIC_DO_POSOK  = 4'h3,
    CTIC_DO_VELOK  = 4'h4,
    CTIC_DO_ZERO   = 4'h5,
    CTIC_DO_TBLACT = 4'h6,
    CTIC_DO_ERROR  = 4'h7
  } ctic_do_fn_t;
  // Input 1..7 then output 1..5 assignments
  typedef struct packed {
    ctic_di_fn_t [7:1] din;
    ctic_do_fn_t [5:1] dout;
  } ctic_io_map_t;
  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ctic_req_t;
  // Menu state
  typedef enum logic [2:0] {
    CTIC_M_LOCKED = 3'b001,
    CTIC_M_OPEN   = 3'b010,
    CTIC_M_IDLE   = 3'b100
  } ctic_menu_t;
endpackage

// [ctic_config_assertions.sv]
// Concurrent checks on the ports of the configuration block.
// Assumes a bind onto ctic_config, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ctic_config_assertions
  import ctic_pkg::*;
(
  // Clock, reset and register port
  input wire logic                   clk_sys_in,
  input wire logic                   reset_in,
  input wire ctic_pkg::ctic_req_t    req_in,
  input wire logic [15:0]            rdata_out,
  input wire logic                   rdata_hex_out,
  // Motor events
  input wire logic                   motor_mismatch_in,
  input wire logic                   motor_ext_change_in,
  // Decoded results
  input wire ctic_pkg::ctic_io_map_t io_map_out,
  input wire logic signed [7:0]      op_mode_out,
  input wire logic [15:0]            gear_num_out,
  input wire logic                   gear_active_out,
  input wire logic [15:0]            speed_factor_out,
  input wire logic                   speed_active_out,
  input wire logic [3:0]             analog_src_out,
  input wire logic [3:0]             loop_load_out,
  input wire logic [3:0]             loop_app_out,
  input wire logic                   save_pulse_out,
  input wire logic                   menu_locked_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  logic save_hit;
  // Save offset is never locked, so any strobe there counts
  assign save_hit = req_in.wr && req_in.addr == 4'h0;
  sequence save_wr;
    save_hit;
  endsequence
  sequence guarded_rd;
    menu_locked_out && req_in.rd && req_in.addr >= 4'h2 && req_in.addr <= 4'h6;
  endsequence
  chk_hex_flag: assert property (rdata_hex_out == (rdata_out > 16'h270f))
    else $error("hex flag disagrees with read value");
  chk_table_mode: assert property (io_map_out.din[6] == CTIC_DI_TBLGO |->
    op_mode_out == 8'sd1 && io_map_out.dout[4] == CTIC_DO_TBLACT)
    else $error("table map without table mode");
  chk_gear_gate: assert property (gear_active_out == (op_mode_out == -8'sd4)
    && (gear_active_out || gear_num_out == 16'h0000))
    else $error("gear factor outside pulse modes");
  chk_speed_gate: assert property (speed_active_out == (analog_src_out != 4'h0)
    && (speed_active_out || speed_factor_out == 16'h0000))
    else $error("speed factor outside analog modes");
  chk_speed_max: assert property (speed_factor_out <= 16'h0176)
    else $error("speed factor above maximum");
  chk_velocity_out: assert property (speed_active_out |->
    io_map_out.dout[3] == CTIC_DO_VELOK && op_mode_out == -8'sd3)
    else $error("analog mode without velocity output");
  chk_save_pulse: assert property (save_wr |=> save_pulse_out)
    else $error("save pulse missing");
  chk_loop_on_save: assert property ($changed(loop_load_out) || $changed(loop_app_out) |->
    $past(save_hit, 1) || $past(save_hit, 2))
    else $error("loop setup changed without save");
  chk_lock_event: assert property (motor_mismatch_in || motor_ext_change_in |=> menu_locked_out)
    else $error("motor event did not lock menus");
  chk_rd_locked: assert property (guarded_rd |=> rdata_out == 16'h0000)
    else $error("locked parameter was readable");
endmodule
`default_nettype wire

// [ctic_panel_model.sv]
// Panel or host model driving the register port.
// Assumes requests are taken on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ctic_panel_model
  import ctic_pkg::*;
(
  // Clock and register port
  input wire logic                clk_sys_in,
  output var ctic_pkg::ctic_req_t req_out,
  input wire logic [15:0]         rdata_in,
  input wire logic                hex_in
);
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  initial req_out = '0;
  // Strobe lasts one cycle and drops at the edge that takes it
  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    req_out <= '0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic read_reg(input logic [3:0] a, output logic [15:0] v, output logic h);
    @(posedge clk_sys_in);
    req_out <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    req_out <= '0;
    #1;
    v = rdata_in;
    h = hex_in;
  endtask
  // A motor confirmation is always followed by a save
  task automatic confirm_motor(input logic [15:0] m);
    write_reg(4'h1, m);
    write_reg(4'h0, 16'h0000);
  endtask
endmodule
`default_nettype wire

// [command_type_io_config_tb_top.sv]
// Self-checking bench for the configuration block.
// Assumes the package, block, model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module command_type_io_config_tb_top;
  import ctic_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic motor_mm = 1'b0;
  logic motor_ext = 1'b0;
  ctic_req_t req;
  ctic_io_map_t map;
  logic signed [7:0] opm;
  logic [15:0] rdata, gnum, gden, spd, rv;
  logic [3:0] asrc, lload, lapp, t;
  logic hex, gact, sact, loff, aopen, savep, unsv, lock, mopen, rh;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [3:0] types [7] = '{4'h0, 4'h2, 4'h7, 4'h8, 4'h9, 4'h1, 4'h6};
  wire [15:0] dec = {opm, asrc, 2'b00, gact, sact};
  wire [15:0] cfgv = {4'h0, lapp, lload, 2'b00, loff, aopen};
  always #50 clk_sys_in = ~clk_sys_in;
  // Short idle count keeps the menu timeout test brief
  ctic_config #(.IDLE_CYCLES(20)) u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .req_in(req),
    .rdata_out(rdata), .rdata_hex_out(hex), .motor_mismatch_in(motor_mm), .motor_ext_change_in(motor_ext),
    .io_map_out(map), .op_mode_out(opm), .gear_num_out(gnum), .gear_den_out(gden), .gear_active_out(gact),
    .speed_factor_out(spd), .speed_active_out(sact), .analog_src_out(asrc), .limits_off_out(loff),
    .alarm_open_out(aopen), .loop_load_out(lload), .loop_app_out(lapp), .save_pulse_out(savep),
    .unsaved_out(unsv), .menu_locked_out(lock), .menu_open_out(mopen));
  ctic_panel_model u_panel (.clk_sys_in(clk_sys_in), .req_out(req), .rdata_in(rdata), .hex_in(hex));
  // ----------------------------------------
  // Expectations, compares and helpers
  // ----------------------------------------
  function automatic ctic_io_map_t exp_map(input logic [3:0] c);
    ctic_io_map_t m;
    m.din[1] = (c == 4'h8) ? CTIC_DI_NONE : CTIC_DI_ENABLE;
    m.din[2] = (c == 4'h8) ? CTIC_DI_NONE : CTIC_DI_ERRRST;
    m.din[3] = (c == 4'h8) ? CTIC_DI_NONE : CTIC_DI_HOMEGO;
    m.din[4] = (c == 4'h9) ? CTIC_DI_IDX0 : CTIC_DI_LIMP;
    m.din[5] = (c == 4'h9) ? CTIC_DI_IDX1 : CTIC_DI_LIMN;
    m.din[6] = (c == 4'h9) ? CTIC_DI_TBLGO : CTIC_DI_NONE;
    m.din[7] = CTIC_DI_HOME;
    m.dout[1] = CTIC_DO_READY;
    m.dout[2] = CTIC_DO_BRAKE;
    m.dout[3] = (c == 4'h6 || c == 4'h7) ? CTIC_DO_VELOK : CTIC_DO_POSOK;
    m.dout[4] = (c == 4'h9) ? CTIC_DO_TBLACT : CTIC_DO_ZERO;
    m.dout[5] = CTIC_DO_ERROR;
    return m;
  endfunction
  // Operation mode, analog source and the two gates in one word
  function automatic logic [15:0] exp_dec(input logic [3:0] c);
    logic [7:0] o;
    o = (c <= 4'h2) ? 8'hfc : (c == 4'h6 || c == 4'h7) ? 8'hfd : (c == 4'h9) ? 8'h01 : 8'h00;
    return {o, (c == 4'h6) ? 4'h1 : (c == 4'h7) ? 4'h2 : 4'h0, 2'b00, c <= 4'h2, c == 4'h6 || c == 4'h7};
  endfunction
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_map(input ctic_io_map_t e, input ctic_io_map_t g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] io_map expected %h seen %h", e, g);
    end
  endtask
  task automatic settle();
    @(posedge clk_sys_in);
    #1;
  endtask
  // Decoded outputs follow one edge after the write is taken
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    u_panel.write_reg(a, d);
    settle();
  endtask
  task automatic rd(input logic [3:0] a);
    u_panel.read_reg(a, rv, rh);
  endtask
  task automatic lock_pulse(input logic ext);
    @(posedge clk_sys_in);
    motor_ext <= ext;
    motor_mm <= ~ext;
    @(posedge clk_sys_in);
    motor_ext <= 1'b0;
    motor_mm <= 1'b0;
    #1;
    cmp("locked", 16'h0001, {15'h0, lock});
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    settle();
    cmp("decode", exp_dec(4'h1), dec);
    cmp("gear_den", 16'h03e8, gden);
    cmp("cfg_out", 16'h0011, cfgv);
    cmp_map(exp_map(4'h1), map);
    rd(4'h8);
    cmp("status", 16'h0001, rv);
    rd(4'h2);
    cmp("locked_cmd", 16'h0000, rv);
    $display("test reset done");
    u_panel.confirm_motor(16'h0005);
    rd(4'h2);
    cmp("cmd", 16'h0001, rv);
    foreach (types[i]) begin
      t = types[i];
      wr(4'h2, {12'h000, t});
      cmp("decode", exp_dec(t), dec);
      cmp_map(exp_map(t), map);
    end
    $display("test command types done");
    wr(4'h5, 16'h0190);
    cmp("speed", 16'h0176, spd);
    cmp("gear_off", 16'h0000, gnum);
    wr(4'h3, 16'h2710);
    rd(4'h3);
    cmp("gear_hex", 16'h2711, {rv[15:1], rh});
    wr(4'h3, 16'h270f);
    rd(4'h3);
    cmp("gear_dec", 16'h0000, {15'h0, rh});
    $display("test factors done");
    wr(4'h6, 16'h0070);
    cmp("cfg_out", 16'h0012, cfgv);
    cmp("unsaved", 16'h0001, {15'h0, unsv});
    // Save pulse stands only in the cycle after the strobe
    u_panel.write_reg(4'h0, 16'h0000);
    #1;
    cmp("save_pulse", 16'h0001, {15'h0, savep});
    settle();
    cmp("cfg_out", 16'h0122, cfgv);
    cmp("unsaved", 16'h0000, {15'h0, unsv});
    wr(4'h6, 16'h03e8);
    cmp("cfg_out", 16'h0121, cfgv);
    $display("test config digits done");
    // Still open short of the idle count, closed past it
    repeat (15) @(posedge clk_sys_in);
    #1;
    cmp("menu_open", 16'h0001, {15'h0, mopen});
    repeat (10) @(posedge clk_sys_in);
    #1;
    cmp("menu_open", 16'h0000, {15'h0, mopen});
    rd(4'h8);
    cmp("status_idle", 16'h0004, rv);
    cmp("menu_open", 16'h0001, {15'h0, mopen});
    lock_pulse(1'b0);
    wr(4'h2, 16'h0009);
    cmp("decode", exp_dec(4'h6), dec);
    rd(4'hf);
    cmp("unmapped", 16'h0000, rv);
    u_panel.confirm_motor(16'h0005);
    settle();
    cmp("decode", exp_dec(4'h1), dec);
    rd(4'h6);
    cmp("cfg", 16'h03e9, rv);
    rd(4'h5);
    cmp("speed_rd", 16'h012c, rv);
    lock_pulse(1'b1);
    $display("test menu lock done");
    wrap_up();
  end
endmodule
bind ctic_config ctic_config_assertions u_chk (.clk_sys_in, .reset_in, .req_in, .rdata_out, .rdata_hex_out,
  .motor_mismatch_in, .motor_ext_change_in, .io_map_out, .op_mode_out, .gear_num_out, .gear_active_out,
  .speed_factor_out, .speed_active_out, .analog_src_out, .loop_load_out, .loop_app_out, .save_pulse_out,
  .menu_locked_out);
`default_nettype wire
